/* rtl/lwsp_map.svh */
// constants for the late-write synchronous sram port
// assumes one clock shared with the memory controller
// Summary of operation
// R1 - high clock gate freezes every stage
// R2 - clocked inputs sampled on rising edges only
// R3 - controller loads new address with step low
// R4 - all three selects active select device
// R5 - read start captures external address
// R6 - pipeline read data after two edges
// R7 - write recognised when selected, store low
// R8 - each lane strobe enables its lane
// R9 - write with no strobes changes nothing
// R10 - pipeline write data at third edge
// R11 - flow-through read data after one edge
// R12 - flow-through write data at second edge
// R13 - reads and writes back to back
// R14 - both modes share start and burst logic
// R15 - low address bits preset burst counter
// R16 - step high uses advanced counter address
// R17 - sleep request powers down, no clock
// R18 - mode select low picks flow-through
// R19 - order select low picks linear burst
// R20 - ninth bit enable active low
// R21 - output enable forces drivers off always
// R22 - two-bit counter wraps after four
// R23 - linear order adds one modulo four
// R24 - drivers off during write cycles
// R25 - gated edge keeps read driven, write off
// R26 - interleaved order xors the burst count
// R27 - write uses command address and strobes
`ifndef LWSP_MAP_SVH
`define LWSP_MAP_SVH
`define LWSP_AW         8
`define LWSP_LANES      4
`define LWSP_LANE_W     9
`define LWSP_FIFO_DEPTH 4
`define LWSP_BURST_W    2
`endif

/* rtl/lwsp_pkg.sv */
// types shared by the late-write sram port
// assumes lwsp_map.svh is on the include path
`include "lwsp_map.svh"
package lwsp_pkg;
	typedef logic [`LWSP_AW-1:0]     lwsp_addr_t;
	typedef logic [`LWSP_LANES-1:0]  lwsp_strb_t;
	typedef logic [`LWSP_BURST_W-1:0] lwsp_low_t;
	typedef struct packed {
		logic [`LWSP_LANE_W-1:0] data_lane_d;
		logic [`LWSP_LANE_W-1:0] data_lane_c;
		logic [`LWSP_LANE_W-1:0] data_lane_b;
		logic [`LWSP_LANE_W-1:0] data_lane_a;
	} lwsp_word_t;
	// gray along idle -> read -> write
	typedef enum logic [1:0] {
		LWSP_IDLE  = 2'h0,
		LWSP_READ  = 2'h1,
		LWSP_WRITE = 2'h3
	} lwsp_kind_t;
	typedef struct packed {
		lwsp_kind_t kind;
		lwsp_addr_t addr;
		lwsp_strb_t strb_n;
	} lwsp_stage_t;
	typedef struct packed {
		lwsp_addr_t addr;
		lwsp_strb_t strb_n;
		lwsp_word_t data;
	} lwsp_wr_t;
endpackage : lwsp_pkg

/* rtl/lwsp_port.sv */
// late-write synchronous sram port: command pipeline, burst counter,
// write queue and flip-flop array; assumes pins share i_clk
`timescale 1ns/1ns
`default_nettype none
`include "lwsp_map.svh"

module lwsp_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic [W-1:0]      o_out_data
);
	localparam int PW = $clog2(D);
	logic [W-1:0]  store [D];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0]   count;
	logic          push;
	logic          pop;

	assign o_in_ready  = (count != (PW+1)'(D));
	assign o_out_valid = (count != '0);
	assign o_out_data  = store[rd_ptr];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_ff @(posedge i_clk) begin
		if (push) begin
			store[wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(D - 1)) ? '0 : wr_ptr + PW'(1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(D - 1)) ? '0 : rd_ptr + PW'(1);
			end
			count <= count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule : lwsp_fifo

module lwsp_port (
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_clk_gate_n,
	input  wire logic               i_chip_select_one_n,
	input  wire logic               i_chip_select_two,
	input  wire logic               i_chip_select_three_n,
	input  wire logic               i_write_n,
	input  wire logic               i_burst_step,
	input  wire lwsp_pkg::lwsp_addr_t i_addr,
	input  wire logic               i_lane_a_strobe_n,
	input  wire logic               i_lane_b_strobe_n,
	input  wire logic               i_lane_c_strobe_n,
	input  wire logic               i_lane_d_strobe_n,
	input  wire lwsp_pkg::lwsp_word_t i_data,
	output lwsp_pkg::lwsp_word_t    o_data,
	output logic                    o_data_oe,
	input  wire logic               i_output_enable_n,
	input  wire logic               i_sleep_request,
	input  wire logic               i_flow_through_select_n,
	input  wire logic               i_linear_order_select_n,
	input  wire logic               i_ninth_bit_enable_n,
	output logic                    o_sleeping,
	output logic                    o_write_busy
);
	import lwsp_pkg::*;

	localparam int LW = `LWSP_LANE_W;

	function automatic lwsp_low_t burst_low(input lwsp_low_t start,
		input lwsp_low_t cnt, input logic inter);
		burst_low = inter ? (start ^ cnt) : lwsp_low_t'(start + cnt); // R23 R26
	endfunction : burst_low

	function automatic lwsp_word_t ninth_mask(input lwsp_word_t w, input logic off);
		logic [`LWSP_LANES*LW-1:0] v;
		v = w;
		for (int l = 0; l < `LWSP_LANES; l++) begin
			if (off) begin
				v[l*LW + LW - 1] = 1'b0;
			end
		end
		ninth_mask = v;
	endfunction : ninth_mask

	lwsp_word_t  mem [2**`LWSP_AW];
	lwsp_kind_t  ctl;
	lwsp_addr_t  base_addr;
	lwsp_low_t   start_low;
	lwsp_low_t   cnt;
	lwsp_stage_t st1;
	lwsp_stage_t st2;
	lwsp_word_t  rd_q;
	lwsp_word_t  out_q;

	logic        selected;
	logic        advance;
	logic        flow;
	lwsp_strb_t  strb_n;
	lwsp_stage_t next_st1;
	lwsp_stage_t cap_st;
	lwsp_wr_t    push_ent;
	logic        push;
	logic        fifo_in_ready;
	logic        pop_valid;
	lwsp_wr_t    pop_ent;
	logic        drive;

	assign selected = ~i_chip_select_one_n & i_chip_select_two & ~i_chip_select_three_n; // R4
	// sleep and gate act combinationally; a full write queue also holds the edge
	assign advance  = ~i_clk_gate_n & ~i_sleep_request & fifo_in_ready; // R1 R17
	assign flow     = ~i_flow_through_select_n; // R18
	assign strb_n   = {i_lane_d_strobe_n, i_lane_c_strobe_n,
		i_lane_b_strobe_n, i_lane_a_strobe_n};

	// same decode in both modes; only data stage depth differs
	always_comb begin // R14
		next_st1 = '{kind: LWSP_IDLE, addr: i_addr, strb_n: strb_n};
		if (!i_burst_step) begin
			if (selected) begin
				next_st1.kind = i_write_n ? LWSP_READ : LWSP_WRITE; // R5 R7
			end
		end else begin
			next_st1.kind = ctl; // R16
			next_st1.addr = {base_addr[`LWSP_AW-1:`LWSP_BURST_W],
				burst_low(start_low, cnt + lwsp_low_t'(1), i_linear_order_select_n)}; // R19
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctl       <= LWSP_IDLE;
			base_addr <= '0;
			start_low <= '0;
			cnt       <= '0;
		end else if (advance) begin
			if (!i_burst_step) begin
				ctl       <= next_st1.kind;
				base_addr <= i_addr; // R5 R3
				start_low <= i_addr[`LWSP_BURST_W-1:0]; // R15
				cnt       <= '0;
			end else if (ctl != LWSP_IDLE) begin
				cnt <= cnt + lwsp_low_t'(1); // R22
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st1 <= '{kind: LWSP_IDLE, addr: '0, strb_n: '1};
			st2 <= '{kind: LWSP_IDLE, addr: '0, strb_n: '1};
		end else if (advance) begin // R1 R2
			st1 <= next_st1; // R13
			st2 <= st1;
		end
	end

	// array read launched at the command edge so flow-through has data after it
	always_ff @(posedge i_clk) begin
		if (advance && next_st1.kind == LWSP_READ) begin
			rd_q <= ninth_mask(mem[next_st1.addr], i_ninth_bit_enable_n); // R11 R20
		end
		if (advance) begin
			out_q <= rd_q; // R6
		end
	end

	assign cap_st   = flow ? st1 : st2; // R10 R12
	assign push     = advance & (cap_st.kind == LWSP_WRITE) & ~(&cap_st.strb_n); // R9
	assign push_ent = '{addr: cap_st.addr, strb_n: cap_st.strb_n, data: i_data}; // R27

	lwsp_fifo #(
		.W ($bits(lwsp_wr_t)),
		.D (`LWSP_FIFO_DEPTH)
	) u_wq (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_in_valid  (push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (push_ent),
		.o_out_valid (pop_valid),
		.i_out_ready (~i_sleep_request),
		.o_out_data  (pop_ent)
	);

	// queued writes hold while the core sleeps
	always_ff @(posedge i_clk) begin
		if (pop_valid && !i_sleep_request) begin
			for (int l = 0; l < `LWSP_LANES; l++) begin
				if (!pop_ent.strb_n[l]) begin // R8
					mem[pop_ent.addr][l*LW +: LW] <= pop_ent.data[l*LW +: LW];
					if (i_ninth_bit_enable_n) begin // R20
						mem[pop_ent.addr][l*LW + LW - 1] <= 1'b0;
					end
				end
			end
		end
	end

	// a gated edge leaves the stage as is: reads stay driven, writes stay off
	assign drive     = (cap_st.kind == LWSP_READ); // R24 R25
	assign o_data_oe = drive & ~i_output_enable_n & ~i_sleep_request; // R21 R17
	assign o_data    = flow ? rd_q : out_q;
	assign o_sleeping   = i_sleep_request;
	assign o_write_busy = pop_valid;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_gate_freeze: assert property ( // R1
		i_clk_gate_n |=> $stable(st1) && $stable(st2) && $stable(cnt))
		else $error("stage moved on a gated edge");
	a_deselect_any: assert property ( // R4
		advance && !i_burst_step && !selected |=> st1.kind == LWSP_IDLE && ctl == LWSP_IDLE)
		else $error("inactive select did not deselect");
	a_read_start: assert property ( // R5
		advance && !i_burst_step && selected && i_write_n
		|=> st1.kind == LWSP_READ && base_addr == $past(i_addr))
		else $error("read start did not capture address");
	a_write_cmd: assert property ( // R7
		advance && !i_burst_step && selected && !i_write_n |=> st1.kind == LWSP_WRITE)
		else $error("write command not recognised");
	a_noop_write: assert property ( // R9
		advance && cap_st.kind == LWSP_WRITE && (&cap_st.strb_n) && !pop_valid |=> !pop_valid)
		else $error("write with no lanes queued");
	a_pipe_latency: assert property ( // R6
		advance && next_st1.kind == LWSP_READ && !flow ##1
		advance && !flow ##1 !i_output_enable_n && !i_sleep_request && !flow
		|-> o_data_oe && o_data == $past(rd_q))
		else $error("pipeline read not driven two edges on");
	a_ft_late_write: assert property ( // R12
		advance && next_st1.kind == LWSP_WRITE && strb_n != '1 ##1
		advance && flow |-> push && push_ent.addr == $past(next_st1.addr))
		else $error("flow-through write data not taken");
	a_oe_override: assert property ( // R21
		i_output_enable_n || i_sleep_request |-> !o_data_oe)
		else $error("drivers on while disabled");
	a_write_off: assert property ( // R24
		cap_st.kind == LWSP_WRITE |-> !o_data_oe)
		else $error("drivers on in write cycle");
	a_linear_step: assert property ( // R23
		advance && i_burst_step && ctl != LWSP_IDLE && !i_linear_order_select_n
		|=> st1.addr[1:0] == $past(st1.addr[1:0]) + 2'h1 || $past(st1.kind) == LWSP_IDLE)
		else $error("linear burst did not add one");

	c_pipe_read: cover property (
		advance && next_st1.kind == LWSP_READ && !flow ##1 advance ##1 o_data_oe);
	c_read_write: cover property (
		advance && next_st1.kind == LWSP_READ ##1 advance && next_st1.kind == LWSP_WRITE);
	c_burst_four: cover property (
		advance && i_burst_step && cnt == 2'h3);
	c_queue_full: cover property (!fifo_in_ready);
	c_pipe_write: cover property (
		advance && next_st1.kind == LWSP_WRITE && !flow ##1 advance ##1 push);

	// a gated edge must leave every register but the write queue and array untouched
	a_gate_outputs: assert property ( // R1
		i_clk_gate_n |=> $stable(rd_q) && $stable(out_q))
		else $error("read data moved on a gated edge");
	a_gate_ctl: assert property ( // R1
		i_clk_gate_n |=> $stable(ctl) && $stable(base_addr))
		else $error("burst control moved on a gated edge");
	a_out_hold: assert property ( // R1
		!advance |=> $stable(out_q))
		else $error("output register moved without an edge");

	// sleep stops the pipeline and the write drain alike
	a_sleep_freeze: assert property ( // R17
		i_sleep_request |=> $stable(st1) && $stable(st2))
		else $error("stage moved while asleep");
	a_sleep_flag: assert property ( // R17
		o_sleeping == i_sleep_request)
		else $error("sleep flag does not follow request");
	a_sleep_drain: assert property ( // R17
		i_sleep_request && pop_valid |=> pop_valid)
		else $error("queue drained while asleep");

	// each select alone must be able to deselect
	a_sel_needs_one: assert property ( // R4
		advance && !i_burst_step && i_chip_select_one_n |=> st1.kind == LWSP_IDLE)
		else $error("first select high did not deselect");
	a_sel_needs_two: assert property ( // R4
		advance && !i_burst_step && !i_chip_select_two |=> st1.kind == LWSP_IDLE)
		else $error("second select low did not deselect");
	a_sel_needs_three: assert property ( // R4
		advance && !i_burst_step && i_chip_select_three_n |=> st1.kind == LWSP_IDLE)
		else $error("third select high did not deselect");
	a_idle_off: assert property ( // R4
		cap_st.kind == LWSP_IDLE |-> !o_data_oe)
		else $error("drivers on for an idle stage");

	// address loading and burst stepping
	a_read_addr: assert property ( // R5
		advance && !i_burst_step && selected && i_write_n
		|=> st1.addr == $past(i_addr))
		else $error("read stage lost its address");
	a_preset_low: assert property ( // R15
		advance && !i_burst_step |=> start_low == $past(i_addr[1:0]) && cnt == 2'h0)
		else $error("burst counter not preset");
	a_step_counts: assert property ( // R22
		advance && i_burst_step && ctl != LWSP_IDLE |=> cnt == 2'($past(cnt) + 2'h1))
		else $error("burst counter did not step");
	a_step_addr: assert property ( // R16
		advance && i_burst_step && ctl != LWSP_IDLE
		|=> st1.addr[`LWSP_AW-1:`LWSP_BURST_W] == $past(base_addr[`LWSP_AW-1:`LWSP_BURST_W]))
		else $error("burst left its block of four");
	a_cont_kind: assert property ( // R16
		advance && i_burst_step |=> st1.kind == $past(ctl))
		else $error("continue cycle changed its kind");
	a_inter_step: assert property ( // R26
		advance && i_burst_step && ctl != LWSP_IDLE && i_linear_order_select_n
		|=> st1.addr[1:0] == ($past(start_low) ^ 2'($past(cnt) + 2'h1)))
		else $error("interleaved burst address wrong");
	a_linear_wrap: assert property ( // R23
		advance && i_burst_step && ctl != LWSP_IDLE && !i_linear_order_select_n
		|=> st1.addr[1:0] == 2'($past(start_low) + $past(cnt) + 2'h1))
		else $error("linear burst address wrong");

	// data pipeline depth per mode
	a_ft_read_drive: assert property ( // R11
		advance && next_st1.kind == LWSP_READ && flow ##1
		!i_output_enable_n && !i_sleep_request |-> o_data_oe)
		else $error("flow-through read not driven after one edge");
	a_pipe_out_reg: assert property ( // R6
		advance |=> out_q == $past(rd_q))
		else $error("output register did not take read data");
	a_pipe_write_cap: assert property ( // R10
		advance && next_st1.kind == LWSP_WRITE && strb_n != '1 && !flow ##1
		advance ##1 advance && !flow
		|-> push && push_ent.addr == $past(next_st1.addr, 2))
		else $error("pipeline write data not taken at third edge");
	a_ninth_read: assert property ( // R20
		advance && next_st1.kind == LWSP_READ && i_ninth_bit_enable_n
		|=> !rd_q[8] && !rd_q[17] && !rd_q[26] && !rd_q[35])
		else $error("ninth bit returned while disabled");
	a_lane_a_store: assert property ( // R8
		pop_valid && !i_sleep_request && !pop_ent.strb_n[0] && !i_ninth_bit_enable_n
		|=> mem[$past(pop_ent.addr)][8:0] == $past(pop_ent.data[8:0]))
		else $error("lane a not stored");

	// no turnaround cycle between opposite commands
	a_b2b_rw: assert property ( // R13
		advance && next_st1.kind == LWSP_READ ##1
		advance && !i_burst_step && selected && !i_write_n |=> st1.kind == LWSP_WRITE)
		else $error("write after read was delayed");
	a_b2b_wr: assert property ( // R13
		advance && next_st1.kind == LWSP_WRITE ##1
		advance && !i_burst_step && selected && i_write_n |=> st1.kind == LWSP_READ)
		else $error("read after write was delayed");

	// a gated edge keeps the bus as the stage left it
	a_gated_read_driven: assert property ( // R25
		cap_st.kind == LWSP_READ && i_clk_gate_n |=> cap_st.kind == LWSP_READ)
		else $error("gated read dropped its drivers");
	a_gated_write_off: assert property ( // R25
		cap_st.kind == LWSP_WRITE && i_clk_gate_n |=> !o_data_oe)
		else $error("gated write turned drivers on");
endmodule : lwsp_port
`default_nettype wire

/* sim/lwsp_ctrl_model.sv */
// memory controller model: hands late write data to the sram port
// assumes the bench drives the command pins beside it on the same clock
`timescale 1ns/1ns
`default_nettype none
module lwsp_ctrl_model (
	input  wire logic                 i_clk,
	input  wire logic                 i_clk_gate_n,
	input  wire logic                 i_flow_through_select_n,
	input  wire logic                 i_wr,
	input  wire lwsp_pkg::lwsp_word_t i_wdata,
	output lwsp_pkg::lwsp_word_t      o_data
);
	import lwsp_pkg::*;
	logic       v1, v2;
	lwsp_word_t d1, d2, last;
	initial {v1, v2, last} = '0;
	// stages stand still on gated edges, just as the device's do
	always @(posedge i_clk) if (!i_clk_gate_n) begin
		{v1, d1} <= {i_wr, i_wdata};
		{v2, d2} <= {v1, d1};
	end
	// released bus shows a changing pattern, never the last word
	always_comb begin
		if (!i_flow_through_select_n && v1) o_data = d1;
		else if (i_flow_through_select_n && v2) o_data = d2;
		else o_data = ~last;
	end
	always @(posedge i_clk) last <= o_data;
endmodule : lwsp_ctrl_model
`default_nettype wire

/* sim/test_lwsp_port.sv */
// self-checking bench for the late-write sram port
// assumes lwsp_pkg is compiled first; bench plays the command side
`timescale 1ns/1ns
`default_nettype none
module test_lwsp_port;
	import lwsp_pkg::*;
	logic       i_clk = 0, i_rst = 1, gate_n = 0, cs1_n = 1, cs2 = 0, cs3_n = 1;
	logic       wr_n = 1, step = 0, oe_n = 0, sleep = 0, ft_n = 1, lin_n = 0, p9_n = 0;
	logic       wr = 0, rg = 0, oe, slp, busy;
	logic [2:1] ev;
	lwsp_addr_t addr = '0, base, sa;
	lwsp_strb_t sb_n = '1;
	lwsp_low_t  cnt;
	lwsp_word_t wdata = '0, bus, rdata, mem [256], ed [2:1];
	logic [1:0] kind, r;
	int         num_errors = 0, comparisons = 0;
	lwsp_port dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_clk_gate_n(gate_n),
		.i_chip_select_one_n(cs1_n), .i_chip_select_two(cs2), .i_chip_select_three_n(cs3_n),
		.i_write_n(wr_n), .i_burst_step(step), .i_addr(addr), .i_lane_a_strobe_n(sb_n[0]),
		.i_lane_b_strobe_n(sb_n[1]), .i_lane_c_strobe_n(sb_n[2]), .i_lane_d_strobe_n(sb_n[3]),
		.i_data(bus), .o_data(rdata), .o_data_oe(oe), .i_output_enable_n(oe_n),
		.i_sleep_request(sleep), .i_flow_through_select_n(ft_n),
		.i_linear_order_select_n(lin_n), .i_ninth_bit_enable_n(p9_n),
		.o_sleeping(slp), .o_write_busy(busy));
	lwsp_ctrl_model ctrl_u (.i_clk(i_clk), .i_clk_gate_n(gate_n),
		.i_flow_through_select_n(ft_n), .i_wr(wr), .i_wdata(wdata), .o_data(bus));
	always #5 i_clk = ~i_clk;
	function automatic lwsp_addr_t eff(lwsp_addr_t b, lwsp_low_t c, logic inter);
		return {b[7:2], inter ? b[1:0] ^ c : b[1:0] + c};
	endfunction : eff
	function automatic lwsp_word_t merge(lwsp_word_t o, lwsp_word_t n, lwsp_strb_t s, logic p);
		for (int i = 0; i < 4; i++) begin
			if (!s[i]) o[i*9 +: 9] = n[i*9 +: 9] & {!p, 8'hFF};
		end
		return o;
	endfunction : merge
	task automatic cmp(input logic [35:0] got, input logic [35:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp
	task automatic print_verdict;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	// op 0 deselects through one random select, 1 reads, 2 writes
	task automatic cyc(input logic [1:0] op, input lwsp_addr_t a, input logic st,
		input lwsp_strb_t s);
		@(negedge i_clk);
		gate_n = rg && ($urandom % 6 == 0);
		oe_n = rg && ($urandom % 5 == 0);
		{cs1_n, cs2, cs3_n} = (op == 0) ? 3'h2 ^ (3'h1 << ($urandom % 3)) : 3'h2;
		wr_n = (op != 2);
		step = st;
		addr = a;
		sb_n = s;
		wdata = 36'({$urandom, $urandom});
		wr = (op == 2) && (s != 4'hF);
	endtask : cyc
	// expected output is checked before this edge's command enters the model
	always @(posedge i_clk) begin
		if (i_rst) begin
			ev = '0;
			kind = 0;
		end else if (!sleep) begin
			if (!oe_n) begin
				cmp(oe, ft_n ? ev[2] : ev[1], "drive");
				if (oe === 1'b1) cmp(rdata, ft_n ? ed[2] : ed[1], "read");
			end else cmp(oe, 0, "drive off");
			if (!gate_n) begin
				ev[2] = ev[1];
				ed[2] = ed[1];
				ev[1] = 0;
				if (!step) kind = (cs1_n | !cs2 | cs3_n) ? 0 : (wr_n ? 1 : 2);
				if (!step) {base, cnt} = {addr, 2'h0};
				else cnt++;
				sa = eff(base, cnt, lin_n);
				if (kind == 1) {ev[1], ed[1]} = {1'b1, mem[sa] & {4{!p9_n, 8'hFF}}};
				if (kind == 2) mem[sa] = merge(mem[sa], wdata, sb_n, p9_n);
			end
		end
	end
	initial begin
		repeat (4000) @(posedge i_clk);
		num_errors++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'hF1EFD6B7));
		for (int m = 0; m < 2; m++) begin
			@(negedge i_clk);
			{i_rst, rg, ft_n, p9_n, lin_n} = {2'h2, m[0], m[0], !m[0]};
			repeat (10) @(negedge i_clk);
			i_rst = 0;
			for (int a = 0; a < 256; a++) cyc(2, a[7:0], 0, 4'h0);
			rg = 1;
			// reads of the low half mixed with writes to the high half
			repeat (300) begin
				r = 2'($urandom % 3);
				cyc(r, {r[1], 7'($urandom)}, 0, 4'($urandom));
			end
			rg = 0;
			cyc(2, 8'h85, 0, 4'h0);
			repeat (3) cyc(2, 8'h00, 1, 4'($urandom));
			repeat (4) cyc(0, 8'h00, 0, 4'hF);
			cyc(1, 8'h85, 0, 4'hF);
			repeat (4) cyc(1, 8'h00, 1, 4'hF);
			rg = 1;
			for (int a = 128; a < 256; a++) cyc(1, a[7:0], 0, 4'hF);
			rg = 0;
			repeat (4) cyc(0, 8'h00, 0, 4'hF);
			cmp(busy, 0, "queue drained");
			sleep = 1;
			#2;
			cmp(slp, 1, "sleep");
			cmp(oe, 0, "sleep drive");
			@(negedge i_clk);
			sleep = 0;
		end
		print_verdict();
	end
endmodule : test_lwsp_port
`default_nettype wire
